/* rmw_cfg_checker.sv */
/* Port assertions for the read-modify-write handler.
   Assumes it is bound to rmw_cfg_handler and sees only its ports. */
`timescale 1ns/1ps
module rmw_cfg_checker #(
	parameter int PORT_W = 5
) (
	// Clock and reset
	input wire logic              CORE_CLK_I,
	input wire logic              RESETN_I,
	// Command stream
	input wire rmw_pkg::rmw_sym_s RX_SYM_I,
	input wire logic              RX_VALID_I,
	input wire logic [PORT_W-1:0] RX_PORT_I,
	input wire logic              RX_READY_O,
	// Register access
	input wire logic [9:0]        REG_ADDR_O,
	input wire logic              REG_RD_O,
	input wire logic              REG_WR_O,
	input wire logic              REG_LOCK_O,
	// Reply stream
	input wire rmw_pkg::rmw_sym_s TX_SYM_O,
	input wire logic              TX_VALID_O,
	input wire logic              TX_READY_I,
	input wire logic [PORT_W-1:0] TX_PORT_O
);
	logic              in_pkt_ff;
	logic [PORT_W-1:0] port_ff;

	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);

	// Arrival port, taken with the first symbol; a lone marker opens no packet
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			in_pkt_ff <= 1'b0;
			port_ff   <= '0;
		end else if (RX_VALID_I && RX_READY_O) begin
			in_pkt_ff <= !RX_SYM_I.eop;
			if (!in_pkt_ff && !RX_SYM_I.eop) begin
				port_ff <= RX_PORT_I;
			end
		end
	end

	AST_WR_AFTER_RD: assert property (REG_RD_O |-> ##2 REG_WR_O)
		else $error("write not two cycles after read");
	AST_LOCK_SPAN: assert property (REG_RD_O |-> REG_LOCK_O [*3])
		else $error("lock dropped during update");
	AST_WR_NEEDS_RD: assert property (REG_WR_O |-> $past(REG_RD_O, 2))
		else $error("write without read");
	AST_ADDR_VALID: assert property (REG_RD_O |-> REG_ADDR_O[1:0] == 2'h0 && REG_ADDR_O <= 10'h108)
		else $error("access outside range");
	AST_ADDR_HELD: assert property (REG_RD_O |=> $stable(REG_ADDR_O) [*2])
		else $error("address moved in update");
	AST_REPLY_AFTER_WR: assert property (REG_WR_O |-> ##2 TX_VALID_O)
		else $error("reply late");
	AST_TX_HELD: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_SYM_O))
		else $error("reply symbol lost in stall");
	AST_SAME_PORT: assert property (TX_VALID_O |-> TX_PORT_O == port_ff)
		else $error("reply port wrong");
	AST_PORT_HELD: assert property (TX_VALID_O |=> $stable(TX_PORT_O))
		else $error("reply port moved while reply pending");
endmodule // rmw_cfg_checker

bind rmw_cfg_handler rmw_cfg_checker #(.PORT_W(PORT_W)) rmw_cfg_checker_inst (
	.CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .RX_SYM_I(RX_SYM_I), .RX_VALID_I(RX_VALID_I),
	.RX_PORT_I(RX_PORT_I), .RX_READY_O(RX_READY_O), .REG_ADDR_O(REG_ADDR_O), .REG_RD_O(REG_RD_O),
	.REG_WR_O(REG_WR_O), .REG_LOCK_O(REG_LOCK_O), .TX_SYM_O(TX_SYM_O), .TX_VALID_O(TX_VALID_O),
	.TX_READY_I(TX_READY_I), .TX_PORT_O(TX_PORT_O));

/* rmw_cfg_handler.sv */
/*
 * Configuration-port read-modify-write command handler: parses a command
 * packet, checks it, merges data under mask into one register and sends a
 * reply holding the register's previous value.
 * Assumes a register file that returns read data one cycle after the read
 * strobe and holds off other writers while the lock output is high.
 */
// Overview of operation
// - Only aligned single 32-bit word modify allowed.
// - Packet starts with port address byte zero.
// - Accept only target logical address FEh.
// - Protocol identifier must be 01h.
// - Destination key must match key register.
// - Path length field selects 0,4,8,16 bytes.
// - Received path bytes lead the reply.
// - Two-byte transaction identifier, high byte first.
// - Extended address byte must be zero.
// - Length field equals 8: data then mask.
// - Header CRC must pass before execution.
// - Data CRC checked over data and mask.
// - Masked bits take data, others kept.
// - Reply leaves through the arrival port.
// - Reply header fields in fixed order.
// - Reply transaction identifier copies the command's.
// - Reply data is the pre-update register value.
// - Status byte gives success or error code.
`timescale 1ns/1ps
module rmw_cfg_handler #(
	parameter int PORT_W = 5
) (
	// Clock and reset
	input  wire logic              CORE_CLK_I,
	input  wire logic              RESETN_I,
	// Command stream in
	input  wire rmw_pkg::rmw_sym_s RX_SYM_I,
	input  wire logic              RX_VALID_I,
	input  wire logic [PORT_W-1:0] RX_PORT_I,
	output logic                   RX_READY_O,
	// Destination key register contents
	input  wire logic [7:0]        DEST_KEY_I,
	// Register file access
	output logic [9:0]             REG_ADDR_O,
	output logic                   REG_RD_O,
	input  wire logic [31:0]       REG_RDATA_I,
	output logic                   REG_WR_O,
	output logic [31:0]            REG_WDATA_O,
	output logic                   REG_LOCK_O,
	// Reply stream out
	output rmw_pkg::rmw_sym_s      TX_SYM_O,
	output logic                   TX_VALID_O,
	input  wire logic              TX_READY_I,
	output logic [PORT_W-1:0]      TX_PORT_O
);

	typedef enum logic [3:0] {
		S_PORT, S_HDR, S_DATA, S_EOP, S_DROP, S_SINK, S_READ, S_CAPT, S_WRITE, S_REPLY
	} rmw_state_e;

	rmw_state_e        state_ff;
	rmw_state_e        nxt_state;
	logic              rx_ready_ff;
	logic [4:0]        hdr_idx_ff;
	logic [3:0]        dat_idx_ff;
	logic [5:0]        rep_idx_ff;
	logic [7:0]        rx_crc_ff;
	logic [7:0]        tx_crc_ff;
	logic [7:0]        err_ff;
	logic [1:0]        spal_ff;
	logic [4:0]        spa_n_ff;
	logic [7:0]        spa_mem [16];
	logic [7:0]        src_la_ff;
	logic [15:0]       tid_ff;
	logic [31:0]       addr_ff;
	logic [23:0]       len_ff;
	logic [63:0]       dm_ff;
	logic [31:0]       old_ff;
	logic [PORT_W-1:0] port_ff;

	logic              rx_acc;
	logic              rx_eop;
	logic [7:0]        rx_byte;
	logic [4:0]        spa_pos;
	logic              in_spa;
	logic [4:0]        rel;
	logic [7:0]        fault;
	logic [4:0]        rep_rel;
	rmw_pkg::rmw_sym_s rep_sym;
	logic              push_rdy;
	logic              push;

	assign rx_acc  = RX_VALID_I & rx_ready_ff;
	assign rx_eop  = RX_SYM_I.eop;
	assign rx_byte = RX_SYM_I.data;
	assign spa_pos = 5'(hdr_idx_ff - rmw_pkg::HDR_FIXED_BYTES);
	assign in_spa  = (hdr_idx_ff >= rmw_pkg::HDR_FIXED_BYTES) && (spa_pos < spa_n_ff);
	assign rel     = 5'(spa_pos - spa_n_ff);
	assign rep_rel = 5'(rep_idx_ff - {1'b0, spa_n_ff});
	assign push    = (state_ff == S_REPLY);

	// Sequencing of receive, register access and reply
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			S_PORT: begin
				if (rx_acc && !rx_eop) begin
					nxt_state = (rx_byte == rmw_pkg::CFG_PORT_ADDR) ? S_HDR : S_DROP;
				end
			end
			S_HDR: begin
				if (rx_acc) begin
					// A header cut short gives no reply: the return path is unknown
					if (rx_eop) begin
						nxt_state = S_PORT;
					end else if (!in_spa && hdr_idx_ff >= rmw_pkg::HDR_FIXED_BYTES && rel == rmw_pkg::REL_HDR_CRC) begin
						nxt_state = S_DATA;
					end
				end
			end
			S_DATA: begin
				if (rx_acc) begin
					if (rx_eop) begin
						nxt_state = S_REPLY;
					end else if (dat_idx_ff == rmw_pkg::DATA_MASK_BYTES) begin
						nxt_state = S_EOP;
					end
				end
			end
			S_EOP: begin
				if (rx_acc) begin
					if (!rx_eop) begin
						nxt_state = S_SINK;
					end else begin
						nxt_state = (err_ff == rmw_pkg::ST_OK) ? S_READ : S_REPLY;
					end
				end
			end
			S_SINK: begin
				if (rx_acc && rx_eop) begin
					nxt_state = S_REPLY;
				end
			end
			S_DROP: begin
				if (rx_acc && rx_eop) begin
					nxt_state = S_PORT;
				end
			end
			S_READ:  nxt_state = S_CAPT;
			S_CAPT:  nxt_state = S_WRITE;
			S_WRITE: nxt_state = S_REPLY;
			S_REPLY: begin
				if (push_rdy && rep_rel == rmw_pkg::REP_EOP && rep_idx_ff >= {1'b0, spa_n_ff}) begin
					nxt_state = S_PORT;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_ff <= S_PORT;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Input is taken only while a command is being received; a new packet waits
	// until the reply buffer has drained, so the reply tail keeps its port
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rx_ready_ff <= 1'b0;
		end else begin
			rx_ready_ff <= (nxt_state == S_HDR) || (nxt_state == S_DATA) || (nxt_state == S_EOP) ||
				(nxt_state == S_DROP) || (nxt_state == S_SINK) ||
				((nxt_state == S_PORT) && !push && !TX_VALID_O);
		end
	end

	// Fault detected by the current byte; the first fault of a packet is kept
	always_comb begin
		fault = rmw_pkg::ST_OK;
		if (rx_acc && state_ff == S_HDR && !rx_eop) begin
			if (hdr_idx_ff == 5'h00 && rx_byte != rmw_pkg::TARGET_LA) begin
				fault = rmw_pkg::ST_BAD_LA;
			end else if (hdr_idx_ff == 5'h01 && rx_byte != rmw_pkg::PROTO_ID) begin
				fault = rmw_pkg::ST_BAD_TYPE;
			end else if (hdr_idx_ff == 5'h02 && rx_byte[7:2] != rmw_pkg::CMD_TYPE_RMW) begin
				fault = rmw_pkg::ST_BAD_TYPE;
			end else if (hdr_idx_ff == 5'h03 && rx_byte != DEST_KEY_I) begin
				fault = rmw_pkg::ST_BAD_KEY;
			end else if (hdr_idx_ff >= rmw_pkg::HDR_FIXED_BYTES && !in_spa) begin
				if (rel == rmw_pkg::REL_EXT_ADDR && rx_byte != rmw_pkg::EXT_ADDR) begin
					fault = rmw_pkg::ST_NOT_AUTH;
				end else if (rel == rmw_pkg::REL_HDR_CRC) begin
					if (rmw_pkg::crc8(rx_crc_ff, rx_byte) != rmw_pkg::CRC_INIT) begin
						fault = rmw_pkg::ST_HDR_CRC;
					end else if (len_ff != rmw_pkg::CMD_LEN_RMW) begin
						fault = rmw_pkg::ST_BAD_LEN;
					end else if (addr_ff[1:0] != 2'h0 || addr_ff > rmw_pkg::ADDR_MAX) begin
						fault = rmw_pkg::ST_NOT_AUTH;
					end
				end
			end
		end else if (rx_acc && state_ff == S_DATA) begin
			if (rx_eop) begin
				fault = rmw_pkg::ST_EARLY_EOP;
			end else if (dat_idx_ff == rmw_pkg::DATA_MASK_BYTES &&
				rmw_pkg::crc8(rx_crc_ff, rx_byte) != rmw_pkg::CRC_INIT) begin
				fault = rmw_pkg::ST_DATA_CRC;
			end
		end else if (rx_acc && state_ff == S_EOP && !rx_eop) begin
			fault = rmw_pkg::ST_TOO_MUCH;
		end
	end

	// Status of the packet in hand
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			err_ff <= rmw_pkg::ST_OK;
		end else if (state_ff == S_PORT && rx_acc) begin
			err_ff <= rmw_pkg::ST_OK;
		end else if (err_ff == rmw_pkg::ST_OK && fault != rmw_pkg::ST_OK) begin
			err_ff <= fault;
		end
	end

	// Header and data byte counters
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			hdr_idx_ff <= 5'h00;
			dat_idx_ff <= 4'h0;
		end else if (state_ff == S_PORT) begin
			hdr_idx_ff <= 5'h00;
			dat_idx_ff <= 4'h0;
		end else if (rx_acc && state_ff == S_HDR) begin
			hdr_idx_ff <= 5'(hdr_idx_ff + 5'h01);
		end else if (rx_acc && state_ff == S_DATA) begin
			dat_idx_ff <= 4'(dat_idx_ff + 4'h1);
		end
	end

	// Running CRC, restarted after the header check byte
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rx_crc_ff <= rmw_pkg::CRC_INIT;
		end else if (state_ff == S_PORT) begin
			rx_crc_ff <= rmw_pkg::CRC_INIT;
		end else if (rx_acc && !rx_eop && (state_ff == S_HDR || state_ff == S_DATA)) begin
			if (state_ff == S_HDR && !in_spa && hdr_idx_ff >= rmw_pkg::HDR_FIXED_BYTES &&
				rel == rmw_pkg::REL_HDR_CRC) begin
				rx_crc_ff <= rmw_pkg::CRC_INIT;
			end else begin
				rx_crc_ff <= rmw_pkg::crc8(rx_crc_ff, rx_byte);
			end
		end
	end

	// Arrival port is remembered so the reply can go back the same way
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			port_ff <= '0;
		end else if (state_ff == S_PORT && rx_acc && !rx_eop) begin
			port_ff <= RX_PORT_I;
		end
	end
	assign TX_PORT_O = port_ff;

	// Path length decode; a field of 3 means sixteen bytes
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			spal_ff  <= 2'h0;
			spa_n_ff <= 5'h00;
		end else if (state_ff == S_PORT) begin
			spal_ff  <= 2'h0;
			spa_n_ff <= 5'h00;
		end else if (rx_acc && !rx_eop && state_ff == S_HDR && hdr_idx_ff == 5'h02) begin
			spal_ff  <= rx_byte[1:0];
			spa_n_ff <= (rx_byte[1:0] == 2'h3) ? 5'h10 : {1'b0, rx_byte[1:0], 2'h0};
		end
	end

	// Path bytes are kept in arrival order for the reply
	always_ff @(posedge CORE_CLK_I) begin
		if (rx_acc && !rx_eop && state_ff == S_HDR && in_spa) begin
			spa_mem[spa_pos[3:0]] <= rx_byte;
		end
	end

	// Header fields, most significant byte first
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			src_la_ff <= 8'h00;
			tid_ff    <= 16'h0000;
			addr_ff   <= 32'h00000000;
			len_ff    <= 24'h000000;
		end else if (rx_acc && !rx_eop && state_ff == S_HDR && !in_spa &&
			hdr_idx_ff >= rmw_pkg::HDR_FIXED_BYTES) begin
			if (rel == rmw_pkg::REL_SRC_LA) begin
				src_la_ff <= rx_byte;
			end
			if (rel == rmw_pkg::REL_TID_MS || rel == rmw_pkg::REL_TID_LS) begin
				tid_ff <= {tid_ff[7:0], rx_byte};
			end
			if (rel >= rmw_pkg::REL_ADDR_FIRST && rel <= rmw_pkg::REL_ADDR_LAST) begin
				addr_ff <= {addr_ff[23:0], rx_byte};
			end
			if (rel >= rmw_pkg::REL_LEN_FIRST && rel <= rmw_pkg::REL_LEN_LAST) begin
				len_ff <= {len_ff[15:0], rx_byte};
			end
		end
	end

	// Data word then mask word, shifted in high byte first
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			dm_ff <= 64'h0000000000000000;
		end else if (rx_acc && !rx_eop && state_ff == S_DATA && dat_idx_ff < rmw_pkg::DATA_MASK_BYTES) begin
			dm_ff <= {dm_ff[55:0], rx_byte};
		end
	end

	// Register access: lock spans the read and the write so no writer slips between
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			REG_RD_O    <= 1'b0;
			REG_WR_O    <= 1'b0;
			REG_LOCK_O  <= 1'b0;
			REG_ADDR_O  <= 10'h000;
			REG_WDATA_O <= 32'h00000000;
		end else begin
			REG_RD_O <= (nxt_state == S_READ);
			REG_WR_O <= (nxt_state == S_WRITE);
			REG_LOCK_O <= (nxt_state == S_READ) || (nxt_state == S_CAPT) || (nxt_state == S_WRITE);
			if (nxt_state == S_READ) begin
				REG_ADDR_O <= addr_ff[9:0];
			end
			if (state_ff == S_CAPT) begin
				REG_WDATA_O <= (dm_ff[31:0] & dm_ff[63:32]) | (~dm_ff[31:0] & REG_RDATA_I);
			end
		end
	end

	// Previous register value for the reply; zero when nothing was executed
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			old_ff <= 32'h00000000;
		end else if (state_ff == S_PORT) begin
			old_ff <= 32'h00000000;
		end else if (state_ff == S_CAPT) begin
			old_ff <= REG_RDATA_I;
		end
	end

	// Reply symbol for the current position
	always_comb begin
		rep_sym.eop  = 1'b0;
		rep_sym.data = 8'h00;
		if (rep_idx_ff < {1'b0, spa_n_ff}) begin
			rep_sym.data = spa_mem[rep_idx_ff[3:0]];
		end else begin
			unique case (rep_rel)
				5'h00: rep_sym.data = src_la_ff;
				5'h01: rep_sym.data = rmw_pkg::PROTO_ID;
				5'h02: rep_sym.data = {rmw_pkg::REPLY_TYPE_RMW, spal_ff};
				5'h03: rep_sym.data = err_ff;
				5'h04: rep_sym.data = rmw_pkg::TARGET_LA;
				5'h05: rep_sym.data = tid_ff[15:8];
				5'h06: rep_sym.data = tid_ff[7:0];
				5'h07: rep_sym.data = rmw_pkg::RESERVED_BYTE;
				5'h08: rep_sym.data = rmw_pkg::REPLY_LEN_RMW[23:16];
				5'h09: rep_sym.data = rmw_pkg::REPLY_LEN_RMW[15:8];
				5'h0A: rep_sym.data = rmw_pkg::REPLY_LEN_RMW[7:0];
				5'h0B: rep_sym.data = tx_crc_ff;
				5'h0C: rep_sym.data = old_ff[31:24];
				5'h0D: rep_sym.data = old_ff[23:16];
				5'h0E: rep_sym.data = old_ff[15:8];
				5'h0F: rep_sym.data = old_ff[7:0];
				5'h10: rep_sym.data = tx_crc_ff;
				default: rep_sym.eop = 1'b1;
			endcase
		end
	end

	// Reply position and CRC; the CRC restarts after the header check byte
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rep_idx_ff <= 6'h00;
			tx_crc_ff  <= rmw_pkg::CRC_INIT;
		end else if (state_ff != S_REPLY) begin
			rep_idx_ff <= 6'h00;
			tx_crc_ff  <= rmw_pkg::CRC_INIT;
		end else if (push_rdy) begin
			rep_idx_ff <= 6'(rep_idx_ff + 6'h01);
			if (rep_idx_ff >= {1'b0, spa_n_ff}) begin
				if (rep_rel == rmw_pkg::REL_HDR_CRC) begin
					tx_crc_ff <= rmw_pkg::CRC_INIT;
				end else if (rep_rel < rmw_pkg::REL_HDR_CRC ||
					(rep_rel >= rmw_pkg::REP_DATA_FIRST && rep_rel <= rmw_pkg::REP_DATA_LAST)) begin
					tx_crc_ff <= rmw_pkg::crc8(tx_crc_ff, rep_sym.data);
				end
			end
		end
	end

	// Reply buffer: a stalled receiver back-pressures the reply sequencer
	rmw_skid2 #(
		.WIDTH ($bits(rmw_pkg::rmw_sym_s))
	) u_reply_buf (
		.clk_i       (CORE_CLK_I),
		.rst_n_i     (RESETN_I),
		.in_data_i   (rep_sym),
		.in_valid_i  (push),
		.in_ready_o  (push_rdy),
		.out_data_o  (TX_SYM_O),
		.out_valid_o (TX_VALID_O),
		.out_ready_i (TX_READY_I)
	);

	// Ready toward the command source
	assign RX_READY_O = rx_ready_ff;

endmodule // rmw_cfg_handler

/* rmw_pkg.sv */
/*
 * Shared constants, carrier type and CRC function for the configuration-port
 * read-modify-write command handler and its reply buffer.
 * Assumes a byte-wide symbol stream in which an end-of-packet marker travels
 * as its own symbol with the eop flag set.
 */
package rmw_pkg;

	// Header field values expected in a command and sent in a reply
	localparam logic [7:0]  CFG_PORT_ADDR   = 8'h00;
	localparam logic [7:0]  TARGET_LA       = 8'hFE;
	localparam logic [7:0]  PROTO_ID        = 8'h01;
	localparam logic [7:0]  EXT_ADDR        = 8'h00;
	localparam logic [7:0]  RESERVED_BYTE   = 8'h00;
	localparam logic [5:0]  CMD_TYPE_RMW    = 6'h17;
	localparam logic [5:0]  REPLY_TYPE_RMW  = 6'h07;
	localparam logic [23:0] CMD_LEN_RMW     = 24'h000008;
	localparam logic [23:0] REPLY_LEN_RMW   = 24'h000004;
	localparam logic [31:0] ADDR_MAX        = 32'h00000109;

	// Positions within the packet
	localparam logic [4:0]  HDR_FIXED_BYTES = 5'h04;
	localparam logic [4:0]  REL_SRC_LA      = 5'h00;
	localparam logic [4:0]  REL_TID_MS      = 5'h01;
	localparam logic [4:0]  REL_TID_LS      = 5'h02;
	localparam logic [4:0]  REL_EXT_ADDR    = 5'h03;
	localparam logic [4:0]  REL_ADDR_FIRST  = 5'h04;
	localparam logic [4:0]  REL_ADDR_LAST   = 5'h07;
	localparam logic [4:0]  REL_LEN_FIRST   = 5'h08;
	localparam logic [4:0]  REL_LEN_LAST    = 5'h0A;
	localparam logic [4:0]  REL_HDR_CRC     = 5'h0B;
	localparam logic [3:0]  DATA_MASK_BYTES = 4'h8;
	localparam logic [4:0]  REP_DATA_FIRST  = 5'h0C;
	localparam logic [4:0]  REP_DATA_LAST   = 5'h0F;
	localparam logic [4:0]  REP_DATA_CRC    = 5'h10;
	localparam logic [4:0]  REP_EOP         = 5'h11;

	// Reply status codes
	localparam logic [7:0]  ST_OK           = 8'h00;
	localparam logic [7:0]  ST_HDR_CRC      = 8'h01;
	localparam logic [7:0]  ST_BAD_TYPE     = 8'h02;
	localparam logic [7:0]  ST_BAD_KEY      = 8'h03;
	localparam logic [7:0]  ST_DATA_CRC     = 8'h04;
	localparam logic [7:0]  ST_EARLY_EOP    = 8'h05;
	localparam logic [7:0]  ST_TOO_MUCH     = 8'h06;
	localparam logic [7:0]  ST_NOT_AUTH     = 8'h0A;
	localparam logic [7:0]  ST_BAD_LEN      = 8'h0B;
	localparam logic [7:0]  ST_BAD_LA       = 8'h0C;

	// Reflected CRC-8 polynomial and start value
	localparam logic [7:0]  CRC_POLY_REFL   = 8'hE0;
	localparam logic [7:0]  CRC_INIT        = 8'h00;

	// One stream symbol: a data byte or an end-of-packet marker
	typedef struct packed {
		logic       eop;
		logic [7:0] data;
	} rmw_sym_s;

	// Fold one byte into the running CRC, least significant bit first
	function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] d);
		logic [7:0] c;
		c = crc ^ d;
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
		end
		return c;
	endfunction

endpackage

/* rmw_read_modify_write_handler_tb_top.sv */
/* Self-checking bench for the read-modify-write handler.
   Assumes each reply is drained before the next command is sent. */
`timescale 1ns/1ps
module rmw_read_modify_write_handler_tb_top;
	localparam logic [7:0] ST_TAB [15] = '{8'h00, 8'h01, 8'h03, 8'h02, 8'h0C, 8'h0A, 8'h0A, 8'h0B,
		8'h04, 8'h0A, 8'h05, 8'h06, 8'h02, 8'h00, 8'h00};
	logic              clk, rst_n, rx_valid, rx_ready, tx_valid, tx_ready, reg_rd, reg_wr, reg_lock;
	rmw_pkg::rmw_sym_s rx_sym, tx_sym;
	logic [4:0]        rx_port, tx_port;
	logic [9:0]        reg_addr;
	logic [31:0]       reg_rdata, reg_wdata;
	logic [31:0]       shadow [0:66];
	logic [8:0]        got [$];
	int                n_errors = 0;
	int                n_compared = 0;
	int                cycles = 0;

	// Handler and its register file
	rmw_cfg_handler rmw_cfg_handler_inst (.CORE_CLK_I(clk), .RESETN_I(rst_n), .RX_SYM_I(rx_sym),
		.RX_VALID_I(rx_valid), .RX_PORT_I(rx_port), .RX_READY_O(rx_ready), .DEST_KEY_I(8'h20),
		.REG_ADDR_O(reg_addr), .REG_RD_O(reg_rd), .REG_RDATA_I(reg_rdata), .REG_WR_O(reg_wr),
		.REG_WDATA_O(reg_wdata), .REG_LOCK_O(reg_lock), .TX_SYM_O(tx_sym), .TX_VALID_O(tx_valid),
		.TX_READY_I(tx_ready), .TX_PORT_O(tx_port));
	rmw_reg_model rmw_reg_model_inst (.clk_i(clk), .rst_n_i(rst_n), .addr_i(reg_addr), .rd_i(reg_rd),
		.wr_i(reg_wr), .wdata_i(reg_wdata), .rdata_o(reg_rdata));

	function automatic logic [7:0] crc_of(input logic [7:0] q[$]);
		logic [7:0] c;
		c = 8'h00;
		foreach (q[i]) begin
			c = c ^ q[i];
			repeat (8) c = c[0] ? ((c >> 1) ^ 8'hE0) : (c >> 1);
		end
		return c;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic conclude();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Symbol is held until the edge that sees ready high
	task automatic put(input logic e, input logic [7:0] b);
		rx_sym = '{e, b};
		rx_valid = 1'b1;
		while (!rx_ready) @(negedge clk);
		@(negedge clk);
	endtask

	// Receiver stalls at random to exercise the reply buffer
	task automatic collect();
		got.delete();
		while (got.size() == 0 || !got[$][8]) begin
			@(negedge clk);
			tx_ready = $urandom_range(0, 2) != 0;
			if (tx_valid && tx_ready) got.push_back(tx_sym);
		end
		@(negedge clk);
		tx_ready = 1'b0;
	endtask

	// Mode 0 executes; modes 10, 11 and 14 cut or lengthen the packet, other modes break one field each
	task automatic run(input int md, input logic [1:0] sp, input logic [9:0] a, input logic [31:0] d, m);
		logic [7:0]  h[$], dm[$], pth[$], r[$], dv[$], all[$];
		logic [15:0] tid;
		logic [7:0]  sla;
		logic [31:0] old;
		int          cut;
		tid = 16'($urandom);
		sla = 8'($urandom);
		rx_port = 5'($urandom);
		repeat (sp == 2'h3 ? 16 : 4 * sp) pth.push_back(8'($urandom_range(1, 31)));
		h = {md == 4 ? 8'hFD : 8'hFE, md == 3 ? 8'h02 : 8'h01, 8'({md == 12 ? 6'h1F : rmw_pkg::CMD_TYPE_RMW, sp}),
			md == 2 ? 8'h21 : 8'h20, pth, sla, tid[15:8], tid[7:0], 8'(md == 9), 8'h00, 8'h00, 8'(a >> 8),
			a[7:0], 8'h00, 8'h00, md == 7 ? 8'h04 : 8'h08};
		h.push_back(crc_of(h) ^ 8'(md == 1));
		for (int i = 7; i >= 0; i--) dm.push_back(8'({d, m} >> (8 * i)));
		all = {h, dm, crc_of(dm) ^ 8'(md == 8)};
		if (md == 11) all.push_back(8'h5A);
		cut = md == 14 ? 6 : md == 10 ? h.size() + 5 : all.size();
		put(1'b0, 8'(md == 13));
		for (int i = 0; i < cut; i++) put(1'b0, all[i]);
		put(1'b1, 8'h00);
		rx_valid = 1'b0;
		if (md > 12) begin
			repeat (30) begin
				@(negedge clk);
				check(32'(tx_valid), 32'h0);
			end
			return;
		end
		old = md == 0 ? shadow[a >> 2] : 32'h0;
		if (md == 0) shadow[a >> 2] = (m & d) | (~m & old);
		for (int i = 3; i >= 0; i--) dv.push_back(8'(old >> (8 * i)));
		r = {sla, 8'h01, 8'({rmw_pkg::REPLY_TYPE_RMW, sp}), ST_TAB[md], 8'hFE, tid[15:8], tid[7:0], 8'h00,
			8'h00, 8'h00, 8'h04};
		r = {pth, r, crc_of(r), dv, crc_of(dv)};
		collect();
		check(got.size(), r.size() + 1);
		foreach (r[i]) check(got[i], {1'b0, r[i]});
		check(got[r.size()], 9'h100);
		check(tx_port, rx_port);
	endtask

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Cycle ceiling cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles > 20000) begin
			n_errors++;
			conclude();
		end
	end

	// Fault table first, then boundary and random commands
	initial begin
		rst_n = 1'b0;
		rx_valid = 1'b0;
		rx_sym = '0;
		rx_port = 5'h00;
		tx_ready = 1'b0;
		foreach (shadow[i]) shadow[i] = 32'hA5A50000 | i;
		void'($urandom(6));
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		for (int md = 0; md < 15; md++)
			run(md, 2'(md), md == 5 ? 10'h006 : md == 6 ? 10'h10C : 10'h108, 32'(md), 32'hFFFFFFFF);
		run(0, 2'h3, 10'h108, 32'hFFFF0000, 32'h0F0F0F0F);
		run(0, 2'h0, 10'h108, 32'h00000000, 32'h00000000);
		run(0, 2'h1, 10'h000, 32'h12345678, 32'hFFFFFFFF);
		repeat (60) run(0, 2'($urandom), 10'($urandom_range(0, 66) * 4), $urandom, $urandom);
		conclude();
	end
endmodule // rmw_read_modify_write_handler_tb_top

/* rmw_reg_model.sv */
/* Register file model facing the handler.
   Assumes one-cycle read latency and 67 words at 0h..108h. */
`timescale 1ns/1ps
module rmw_reg_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Access from the handler
	input  wire logic [9:0]  addr_i,
	input  wire logic        rd_i,
	input  wire logic        wr_i,
	input  wire logic [31:0] wdata_i,
	output logic [31:0]      rdata_o
);
	logic [31:0] mem_ff [0:66];

	// Idle read bus toggles so a late sample never sees stale data
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h0;
			for (int i = 0; i < 67; i++)
				mem_ff[i] <= 32'hA5A50000 | i;
		end else begin
			rdata_o <= rd_i ? mem_ff[addr_i[9:2]] : ~rdata_o;
			if (wr_i)
				mem_ff[addr_i[9:2]] <= wdata_i;
		end
	end
endmodule // rmw_reg_model

/* rmw_skid2.sv */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes the drain side may stall at any time; outputs come from flip-flops.
 */
`timescale 1ns/1ps
module rmw_skid2 #(
	parameter int WIDTH = 9
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	// Drain side
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);

	logic [WIDTH-1:0] skid_data_ff;
	logic             skid_valid_ff;
	logic             push;

	// Ready drops only while the second entry is occupied
	assign in_ready_o = ~skid_valid_ff;
	assign push       = in_valid_i & ~skid_valid_ff;

	// Head entry: refilled from the skid entry first so order is kept
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end else if (!out_valid_o || out_ready_i) begin
			if (skid_valid_ff) begin
				out_valid_o <= 1'b1;
				out_data_o  <= skid_data_ff;
			end else begin
				out_valid_o <= push;
				if (push) begin
					out_data_o <= in_data_i;
				end
			end
		end
	end

	// Second entry catches a word pushed while the head is stalled
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			skid_valid_ff <= 1'b0;
			skid_data_ff  <= '0;
		end else if (!out_valid_o || out_ready_i) begin
			skid_valid_ff <= 1'b0;
		end else if (push) begin
			skid_valid_ff <= 1'b1;
			skid_data_ff  <= in_data_i;
		end
	end

endmodule // rmw_skid2
